/* hdl/adcm_ctrl.sv */
// converter mode sequencing, conversion timing, ready flag and result shift-out
`timescale 1ns/1ps
// Contract
// - sel 01: internal oscillator, drive clock pin
// - sel 10: use external clock directly
// - sel 11: external clock divided by two
// - continuous mode stores results, ready low
// - reset leaves continuous conversion mode selected
// - continuous read shifts results on serial clock
// - first result two periods, then one each
// - single: settle 1 ms, convert, power down
// - single result and ready held until read
// - idle holds filter and modulator in reset
// - power-down switches off everything incl clock pin
// - sel 00: internal oscillator, pin undriven
// - ready set by read, pre-update, power-down
// - mode write resets filter, sets ready flag
// - 16-bit mode register, select 001, reset 0x000A
module adcm_ctrl
  import adcm_pkg::*;
#(
  parameter int DATA_W      = 20,
  parameter int SETTLE_CYCS = SETTLE_CYC
)
(
  input  wire logic              I_REF_CLK,
  input  wire logic              I_NRST,
  input  wire logic              I_REG_WR,
  input  wire logic [2:0]        I_REG_SEL,
  input  wire logic [15:0]       I_REG_WDATA,
  input  wire logic              I_CONT_READ,
  input  wire logic              I_READ_REQ,
  input  wire logic              I_SCLK,
  input  wire logic              I_EXT_CLK,
  input  wire logic [DATA_W-1:0] I_CONV_RESULT,
  output logic      [15:0]       O_MODE,
  output logic      [DATA_W-1:0] O_DATA,
  output logic                   O_RDY_N,
  output logic                   O_DOUT,
  output logic                   O_CLK_OUT,
  output logic                   O_CLK_OE,
  output logic                   O_MOD_RST,
  output logic                   O_PWR_EN
);
  if (DATA_W < 2 || DATA_W > 32 || SETTLE_CYCS < 1 || SETTLE_CYCS > 1_000_000)
  begin : g_param_check
    $error("adcm_ctrl: parameter out of range");
  end

  adcm_clk_if cif ();

  adcm_state_e       state_reg;
  adcm_state_e       state_next;
  logic [15:0]       mode_reg;
  logic [DATA_W-1:0] data_reg;
  logic              rdy_n_reg;
  logic              rdy_n_next;
  logic [13:0]       tick_cnt_reg;
  logic              need2_reg;
  logic [19:0]       settle_reg;
  logic              mod_rst_reg;
  logic              pwr_en_reg;
  logic              sclk1_reg;
  logic              sclk2_reg;
  logic              sclk3_reg;
  logic [DATA_W-1:0] sh_reg;
  logic [5:0]        bcnt_reg;
  logic              busy_reg;
  logic [2:0]        md;
  logic [2:0]        wr_md;
  logic [13:0]       per_ticks;
  logic              mode_wr;
  logic              restart;
  logic              per_end;
  logic              conv_done;
  logic              pre_upd;
  logic              pdn_entry;
  logic              sclk_rise;
  logic              load_cont;
  logic              load_req;
  logic              read_done;

  assign md        = mode_reg[MD_MSB:MD_LSB];
  assign wr_md     = I_REG_WDATA[MD_MSB:MD_LSB];
  assign per_ticks = adcm_rate_ticks(mode_reg[FS_MSB:FS_LSB]);
  assign mode_wr   = I_REG_WR && I_REG_SEL == RS_MODE;
  // a config or io write restarts the filter but keeps the ready flag
  assign restart   = mode_wr || (I_REG_WR && (I_REG_SEL == RS_CFG || I_REG_SEL == RS_IO));
  assign per_end   = state_reg == ST_CONV && cif.tick && !restart
                     && tick_cnt_reg == per_ticks - 14'h0001;
  assign conv_done = per_end && !need2_reg;
  assign pre_upd   = state_reg == ST_CONV && cif.tick && !restart && !need2_reg
                     && tick_cnt_reg == per_ticks - 14'h0002;
  assign pdn_entry = state_next == ST_PDN && state_reg != ST_PDN;
  assign sclk_rise = sclk2_reg & ~sclk3_reg;
  assign load_cont = I_CONT_READ && conv_done;
  assign load_req  = I_READ_REQ && !busy_reg && !load_cont;
  assign read_done = busy_reg && sclk_rise && bcnt_reg == 6'h00;

  // the clock pin is released in power-down; idle keeps the clocks running
  assign cif.sel     = mode_reg[CS_MSB:CS_LSB];
  assign cif.run     = state_reg != ST_PDN;
  assign cif.ext_clk = I_EXT_CLK;

  adcm_clksel u_clksel (
    .i_clk  (I_REF_CLK),
    .i_nrst (I_NRST),
    .cif    (cif.src)
  );

  always_comb
  begin
    state_next = state_reg;
    if (mode_wr)
    begin
      case (wr_md)
        MD_CONT:   state_next = ST_CONV;
        MD_SINGLE: state_next = ST_SETTLE;
        MD_PDN:    state_next = ST_PDN;
        default:   state_next = ST_IDLE;
      endcase
    end
    else
    begin
      case (state_reg)
        ST_SETTLE: if (settle_reg == 20'h00000) state_next = ST_CONV;
        ST_CONV:   if (conv_done && md == MD_SINGLE) state_next = ST_PDN;
        default:   state_next = state_reg;
      endcase
    end
  end

  // a finished conversion wins over every event that sets the flag
  always_comb
  begin
    rdy_n_next = rdy_n_reg;
    if (conv_done)
      rdy_n_next = 1'b0;
    else if (mode_wr || pre_upd || read_done || pdn_entry)
      rdy_n_next = 1'b1;
  end

  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_NRST)
    begin
      state_reg    <= ST_CONV;
      mode_reg     <= MODE_RST;
      data_reg     <= '0;
      rdy_n_reg    <= 1'b1;
      tick_cnt_reg <= 14'h0000;
      need2_reg    <= 1'b1;
      settle_reg   <= 20'h00000;
      mod_rst_reg  <= 1'b0;
      pwr_en_reg   <= 1'b1;
    end
    else
    begin
      state_reg    <= state_next;
      mode_reg     <= mode_wr ? I_REG_WDATA : mode_reg;
      data_reg     <= conv_done ? I_CONV_RESULT : data_reg;
      rdy_n_reg    <= rdy_n_next;
      tick_cnt_reg <= (restart || state_reg != ST_CONV || per_end) ? 14'h0000
                      : (cif.tick ? tick_cnt_reg + 14'h0001 : tick_cnt_reg);
      need2_reg    <= (restart || state_reg != ST_CONV) ? 1'b1
                      : (per_end ? 1'b0 : need2_reg);
      settle_reg   <= (mode_wr && wr_md == MD_SINGLE) ? 20'(SETTLE_CYCS - 1)
                      : (settle_reg != 20'h00000 ? settle_reg - 20'h00001 : settle_reg);
      mod_rst_reg  <= state_next != ST_CONV || restart;
      pwr_en_reg   <= state_next != ST_PDN;
    end
  end

  // host samples a bit at each serial clock rise; the next one follows
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_NRST)
    begin
      sclk1_reg <= 1'b1;
      sclk2_reg <= 1'b1;
      sclk3_reg <= 1'b1;
      sh_reg    <= '0;
      bcnt_reg  <= 6'h00;
      busy_reg  <= 1'b0;
    end
    else
    begin
      sclk1_reg <= I_SCLK;
      sclk2_reg <= sclk1_reg;
      sclk3_reg <= sclk2_reg;
      if (load_cont || load_req)
      begin
        sh_reg   <= load_cont ? I_CONV_RESULT : data_reg;
        bcnt_reg <= 6'(DATA_W - 1);
        busy_reg <= 1'b1;
      end
      else if (busy_reg && sclk_rise)
      begin
        sh_reg   <= {sh_reg[DATA_W-2:0], 1'b0};
        bcnt_reg <= bcnt_reg - 6'h01;
        busy_reg <= bcnt_reg != 6'h00;
      end
    end
  end

  assign O_MODE    = mode_reg;
  assign O_DATA    = data_reg;
  assign O_RDY_N   = rdy_n_reg;
  assign O_DOUT    = sh_reg[DATA_W-1];
  assign O_CLK_OUT = cif.clk_out;
  assign O_CLK_OE  = cif.clk_oe;
  assign O_MOD_RST = mod_rst_reg;
  assign O_PWR_EN  = pwr_en_reg;

  logic [15:0] since_reg;
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_NRST || restart || state_reg != ST_CONV)
      since_reg <= 16'h0000;
    else if (cif.tick && since_reg != 16'hFFFF)
      since_reg <= since_reg + 16'h0001;
  end

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);

  a_reset_mode: assert property (disable iff (1'b0)
    !I_NRST |=> mode_reg == MODE_RST && state_reg == ST_CONV && O_RDY_N)
    else $error("reset did not restore mode register");
  a_write_ready: assert property (mode_wr |=> O_RDY_N && O_MOD_RST)
    else $error("mode write did not reset filter and set ready");
  a_first_result: assert property (
    conv_done |-> since_reg == {1'b0, per_ticks, 1'b0} - 16'h0001
               || since_reg >= {1'b0, per_ticks, 1'b0})
    else $error("first result came before two periods");
  a_cont_store: assert property (
    conv_done |=> O_DATA == $past(I_CONV_RESULT) && !O_RDY_N)
    else $error("conversion result not stored with ready low");
  a_single_done: assert property (
    conv_done && md == MD_SINGLE |=> state_reg == ST_PDN && !O_RDY_N ##1 !O_PWR_EN)
    else $error("single conversion did not power down");
  a_settle_wait: assert property (
    mode_wr && wr_md == MD_SINGLE |=> (state_reg == ST_SETTLE && O_MOD_RST) [*8])
    else $error("single conversion skipped settling");
  a_idle_reset: assert property (
    state_reg == ST_IDLE && !restart |=> O_MOD_RST && O_PWR_EN)
    else $error("idle does not hold filter in reset");
  a_pdn_off: assert property (
    state_reg == ST_PDN && $past(state_reg) == ST_PDN |-> !O_CLK_OE && !O_PWR_EN)
    else $error("power-down left circuitry on");
  a_pdn_ready: assert property (
    pdn_entry && !conv_done |=> O_RDY_N)
    else $error("power-down entry did not set ready");
  a_read_ready: assert property (read_done && !conv_done |=> O_RDY_N)
    else $error("completed read did not set ready");
  a_shift_msb: assert property (load_cont |=> O_DOUT == $past(I_CONV_RESULT[DATA_W-1]))
    else $error("continuous read did not present msb");

  c_single_done: cover property (conv_done && md == MD_SINGLE);
  c_cont_read: cover property (load_cont ##[1:1000] read_done);
  c_idle_entry: cover property (mode_wr && wr_md == MD_IDLE);
  c_req_read: cover property (load_req);
endmodule // adcm_ctrl

/* common/adcm_pkg.sv */
// constants, types and rate table for the converter mode and clock control
package adcm_pkg;
  localparam int          CLK_HZ       = 125_000_000;
  localparam int          OSC_HZ       = 64_000;
  localparam int          OSC_HALF_CYC = CLK_HZ / (2 * OSC_HZ);
  localparam int          SETTLE_US    = 1000;
  localparam int          SETTLE_CYC   = (CLK_HZ / 1_000_000) * SETTLE_US;
  localparam logic [15:0] MODE_RST     = 16'h000A;
  localparam int          MD_MSB       = 15;
  localparam int          MD_LSB       = 13;
  localparam int          CS_MSB       = 7;
  localparam int          CS_LSB       = 6;
  localparam int          FS_MSB       = 3;
  localparam int          FS_LSB       = 0;
  localparam logic [2:0]  RS_MODE      = 3'h1;
  localparam logic [2:0]  RS_CFG       = 3'h2;
  localparam logic [2:0]  RS_IO        = 3'h5;
  localparam logic [2:0]  MD_CONT      = 3'h0;
  localparam logic [2:0]  MD_SINGLE    = 3'h1;
  localparam logic [2:0]  MD_IDLE      = 3'h2;
  localparam logic [2:0]  MD_PDN       = 3'h3;
  localparam logic [1:0]  CS_INT       = 2'h0;
  localparam logic [1:0]  CS_INT_OUT   = 2'h1;
  localparam logic [1:0]  CS_EXT       = 2'h2;
  localparam logic [1:0]  CS_EXT_DIV2  = 2'h3;

  typedef enum logic [1:0] {
    ST_PDN    = 2'b00,
    ST_SETTLE = 2'b01,
    ST_CONV   = 2'b10,
    ST_IDLE   = 2'b11
  } adcm_state_e;

  // converter clock ticks per output-rate period, per update rate code
  function automatic logic [13:0] adcm_rate_ticks(input logic [3:0] fs);
    case (fs)
      4'h1:    adcm_rate_ticks = 14'h0088;
      4'h2:    adcm_rate_ticks = 14'h0108;
      4'h3:    adcm_rate_ticks = 14'h0208;
      4'h4:    adcm_rate_ticks = 14'h0408;
      4'h5:    adcm_rate_ticks = 14'h0500;
      4'h6:    adcm_rate_ticks = 14'h0669;
      4'h7:    adcm_rate_ticks = 14'h0788;
      4'h8:    adcm_rate_ticks = 14'h0CC1;
      4'h9:    adcm_rate_ticks = 14'h0EF8;
      4'hA:    adcm_rate_ticks = 14'h0EF8;
      4'hB:    adcm_rate_ticks = 14'h1400;
      4'hC:    adcm_rate_ticks = 14'h1900;
      4'hD:    adcm_rate_ticks = 14'h1E03;
      4'hE:    adcm_rate_ticks = 14'h2800;
      default: adcm_rate_ticks = 14'h3BF4;
    endcase
  endfunction
endpackage

/* common/adcm_clk_if.sv */
// carrier between the mode control and the converter clock source
`timescale 1ns/1ps
interface adcm_clk_if;
  logic [1:0] sel;
  logic       run;
  logic       ext_clk;
  logic       tick;
  logic       clk_out;
  logic       clk_oe;
  modport ctrl (output sel, output run, output ext_clk,
                input tick, input clk_out, input clk_oe);
  modport src  (input sel, input run, input ext_clk,
                output tick, output clk_out, output clk_oe);
endinterface

/* hdl/adcm_clksel.sv */
// converter clock source: internal oscillator, external pin, external halved
`timescale 1ns/1ps
module adcm_clksel
  import adcm_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_nrst,
  adcm_clk_if.src   cif
);
  logic        ext1_reg;
  logic        ext2_reg;
  logic        ext3_reg;
  logic        half_reg;
  logic [10:0] osc_cnt_reg;
  logic        osc_reg;
  logic        tick_reg;
  logic        oe_reg;
  logic        ext_rise;
  logic        osc_wrap;
  logic        osc_rise;
  logic        src_tick;

  assign ext_rise = ext2_reg & ~ext3_reg;
  assign osc_wrap = osc_cnt_reg == 11'(OSC_HALF_CYC - 1);
  assign osc_rise = osc_wrap & ~osc_reg;
  // halving uses every second external rising edge
  assign src_tick = (cif.sel == CS_EXT)      ? ext_rise :
                    (cif.sel == CS_EXT_DIV2) ? ext_rise & half_reg : osc_rise;

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      ext1_reg    <= 1'b0;
      ext2_reg    <= 1'b0;
      ext3_reg    <= 1'b0;
      half_reg    <= 1'b0;
      osc_cnt_reg <= 11'h000;
      osc_reg     <= 1'b0;
      tick_reg    <= 1'b0;
      oe_reg      <= 1'b0;
    end
    else
    begin
      ext1_reg    <= cif.ext_clk;
      ext2_reg    <= ext1_reg;
      ext3_reg    <= ext2_reg;
      half_reg    <= ext_rise ? ~half_reg : half_reg;
      osc_cnt_reg <= (!cif.run || osc_wrap) ? 11'h000 : osc_cnt_reg + 11'h001;
      osc_reg     <= !cif.run ? 1'b0 : (osc_wrap ? ~osc_reg : osc_reg);
      tick_reg    <= cif.run & src_tick;
      oe_reg      <= cif.run & (cif.sel == CS_INT_OUT);
    end
  end

  assign cif.tick    = tick_reg;
  assign cif.clk_out = osc_reg;
  assign cif.clk_oe  = oe_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_clk_pin_drive: assert property (cif.clk_oe |-> $past(cif.sel) == CS_INT_OUT)
    else $error("clock pin driven outside internal-out selection");
  a_div_two: assert property (
    cif.sel == CS_EXT_DIV2 && $past(cif.sel) == CS_EXT_DIV2 && cif.tick
    |-> $past(half_reg, 2))
    else $error("halved clock ticked on wrong edge");
endmodule // adcm_clksel

/* sim/adcm_host_model.sv */
// host-side partner: external converter clock and serial read-out
`timescale 1ns/1ps
module adcm_host_model
#(
  parameter int DATA_W = 20
)
(
  input  wire logic              i_clk,
  input  wire logic              i_dout,
  input  wire logic              i_start,
  output logic                   o_ext_clk,
  output logic                   o_sclk,
  output logic [DATA_W-1:0]      o_word,
  output logic                   o_done
);
  logic [2:0] ext_cnt = 3'h0;
  int         bits    = 0;
  int         ph      = 0;

  initial
  begin
    o_sclk = 1'b1;
    o_done = 1'b0;
    o_word = '0;
  end

  // external clock at eight reference cycles a period, free running
  always @(posedge i_clk)
  begin
    ext_cnt <= ext_cnt + 3'h1;
    o_ext_clk <= ext_cnt[2];
  end

  // serial clock idles high and only runs within a read, sampled on its rise
  always @(posedge i_clk)
  begin
    if (i_start)
    begin
      bits <= DATA_W;
      ph <= 0;
      o_done <= 1'b0;
    end
    else if (bits > 0)
    begin
      ph <= (ph == 11) ? 0 : ph + 1;
      if (ph == 0)
        o_sclk <= 1'b0;
      if (ph == 6)
      begin
        o_sclk <= 1'b1;
        o_word <= {o_word[DATA_W-2:0], i_dout};
        bits <= bits - 1;
        o_done <= (bits == 1);
      end
    end
  end
endmodule // adcm_host_model

/* sim/tb.sv */
// self-checking bench for the converter mode and clock control
`timescale 1ns/1ps
module tb;
  import adcm_pkg::*;
  localparam int DW = 20;
  logic          I_REF_CLK     = 1'b0;
  logic          I_NRST        = 1'b0;
  logic          I_REG_WR      = 1'b0;
  logic [2:0]    I_REG_SEL     = 3'h0;
  logic [15:0]   I_REG_WDATA   = 16'h0000;
  logic          I_CONT_READ   = 1'b0;
  logic          I_READ_REQ    = 1'b0;
  logic [DW-1:0] I_CONV_RESULT = '0;
  logic          start         = 1'b0;
  logic          sclk;
  logic          ext_clk;
  logic          done;
  logic          clk_out;
  logic          clk_seen;
  logic [DW-1:0] word;
  logic [15:0]   O_MODE;
  logic [DW-1:0] O_DATA;
  logic          O_RDY_N;
  logic          O_DOUT;
  logic          O_CLK_OE;
  logic          O_MOD_RST;
  logic          O_PWR_EN;
  int            fails      = 0;
  int            n_compared = 0;
  int            n;
  int            m;
  int            per;
  logic [3:0]    fs;
  logic [DW-1:0] res;

  // settle shortened so single mode fits the run
  adcm_ctrl #(.DATA_W(DW), .SETTLE_CYCS(50)) adcm_ctrl_inst (
    .I_REF_CLK(I_REF_CLK), .I_NRST(I_NRST), .I_REG_WR(I_REG_WR), .I_REG_SEL(I_REG_SEL),
    .I_REG_WDATA(I_REG_WDATA), .I_CONT_READ(I_CONT_READ), .I_READ_REQ(I_READ_REQ),
    .I_SCLK(sclk), .I_EXT_CLK(ext_clk), .I_CONV_RESULT(I_CONV_RESULT), .O_MODE(O_MODE),
    .O_DATA(O_DATA), .O_RDY_N(O_RDY_N), .O_DOUT(O_DOUT), .O_CLK_OUT(clk_out),
    .O_CLK_OE(O_CLK_OE), .O_MOD_RST(O_MOD_RST), .O_PWR_EN(O_PWR_EN));

  adcm_host_model #(.DATA_W(DW)) adcm_host_model_inst (
    .i_clk(I_REF_CLK), .i_dout(O_DOUT), .i_start(start), .o_ext_clk(ext_clk),
    .o_sclk(sclk), .o_word(word), .o_done(done));

  initial
  begin
    forever #4 I_REF_CLK = ~I_REF_CLK;
  end

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge I_REF_CLK);
    #1;
  endtask

  task automatic wr(input logic [2:0] s, input logic [15:0] v);
    @(posedge I_REF_CLK);
    I_REG_WR <= 1'b1;
    I_REG_SEL <= s;
    I_REG_WDATA <= v;
    @(posedge I_REF_CLK);
    I_REG_WR <= 1'b0;
    #1;
  endtask

  // result and continuous-read level change only just after an edge
  task automatic put(input logic [DW-1:0] v, input logic cr);
    @(posedge I_REF_CLK);
    I_CONV_RESULT <= v;
    I_CONT_READ <= cr;
    #1;
  endtask

  task automatic wait_rdy(input logic t, input int lim, output int k);
    k = 0;
    while (O_RDY_N !== t)
    begin
      if (k >= lim)
      begin
        fails++;
        close_out();
      end
      cyc(1);
      k++;
    end
  endtask

  // host read: serial clock pulses, word compared, ready set afterwards
  task automatic shift_out(input logic [DW-1:0] e);
    int k;
    @(posedge I_REF_CLK);
    start <= 1'b1;
    @(posedge I_REF_CLK);
    start <= 1'b0;
    // let the model clear the done of the previous word before polling
    #1;
    k = 0;
    while (done !== 1'b1)
    begin
      if (k >= 1000)
      begin
        fails++;
        close_out();
      end
      @(posedge I_REF_CLK);
      k++;
    end
    #1;
    chk("word", e, word);
    cyc(6);
    chk("rdy_after_read", 1, O_RDY_N);
  endtask

  // reserved bits always written as zero
  function automatic logic [15:0] mk(input logic [2:0] md, input logic [1:0] cs,
                                     input logic [3:0] f);
    return {md, 5'h00, cs, 2'h0, f};
  endfunction

  function automatic int exp_ticks(input logic [3:0] f);
    return (f == 4'h1) ? 136 : 264;
  endfunction

  initial
  begin
    void'($urandom(26));
    repeat (3) @(posedge I_REF_CLK);
    I_NRST <= 1'b1;
    #1;
    chk("mode", 16'h000A, O_MODE);
    chk("mode_sel", MD_CONT, O_MODE[15:13]);
    chk("rdy_n", 1, O_RDY_N);
    chk("pwr_en", 1, O_PWR_EN);
    for (int c = 0; c < 4; c++)
    begin
      wr(RS_MODE, mk(MD_CONT, c[1:0], 4'h1));
      chk("rdy_n_wr", 1, O_RDY_N);
      chk("mod_rst", 1, O_MOD_RST);
      cyc(2);
      chk("clk_oe", c == 1, O_CLK_OE);
    end
    // external clock direct then halved; tolerance covers tick phase and sync
    for (int c = 2; c < 4; c++)
    begin
      fs = 4'($urandom_range(1, 2));
      res = DW'($urandom);
      put(res, 1'b0);
      wr(RS_MODE, mk(MD_CONT, c[1:0], fs));
      per = exp_ticks(fs) * 8 * (c - 1);
      wait_rdy(1'b0, 3 * per, n);
      chk("first_ok", 1, n > 2 * per - 40 && n < 2 * per + 40);
      chk("data", res, O_DATA);
      wait_rdy(1'b1, 2 * per, n);
      wait_rdy(1'b0, 2 * per, m);
      chk("next_ok", 1, n + m > per - 40 && n + m < per + 40);
      wr(c == 2 ? RS_CFG : RS_IO, 16'h0000);
      wait_rdy(1'b1, 2 * per, n);
      wait_rdy(1'b0, 3 * per, m);
      chk("restart_ok", 1, n + m > 2 * per - 40 && n + m < 2 * per + 40);
    end
    res = DW'($urandom);
    put(res, 1'b1);
    wait_rdy(1'b1, 2 * per, n);
    wait_rdy(1'b0, 2 * per, n);
    shift_out(res);
    res = DW'($urandom);
    put(res, 1'b0);
    wait_rdy(1'b0, 2 * per, n);
    @(posedge I_REF_CLK);
    I_READ_REQ <= 1'b1;
    @(posedge I_REF_CLK);
    I_READ_REQ <= 1'b0;
    shift_out(res);
    res = DW'($urandom);
    put(res, 1'b0);
    wr(RS_MODE, mk(MD_SINGLE, CS_EXT, 4'h1));
    wait_rdy(1'b0, 4000, n);
    chk("single_ok", 1, n > 50 + 2176 - 40 && n < 50 + 2176 + 40);
    cyc(3);
    chk("single_pwr", 0, O_PWR_EN);
    cyc(300);
    chk("single_rdy", 0, O_RDY_N);
    chk("single_data", res, O_DATA);
    @(posedge I_REF_CLK);
    I_READ_REQ <= 1'b1;
    @(posedge I_REF_CLK);
    I_READ_REQ <= 1'b0;
    shift_out(res);
    wr(RS_MODE, mk(MD_IDLE, CS_INT_OUT, 4'h1));
    cyc(20);
    chk("idle_rst", 1, O_MOD_RST);
    chk("idle_clk", 1, O_CLK_OE);
    // internal oscillator half period seen on the clock output
    clk_seen = clk_out;
    n = 0;
    while (clk_out === clk_seen && n < 3000)
    begin
      cyc(1);
      n++;
    end
    clk_seen = clk_out;
    m = 0;
    while (clk_out === clk_seen && m < 3000)
    begin
      cyc(1);
      m++;
    end
    chk("clk_half", OSC_HALF_CYC, m);
    // unbuilt mode codes behave as idle
    wr(RS_MODE, mk(3'h4, CS_INT_OUT, 4'h1));
    cyc(3);
    chk("cal_rst", 1, O_MOD_RST);
    chk("cal_pwr", 1, O_PWR_EN);
    wr(RS_MODE, mk(MD_PDN, CS_INT_OUT, 4'h1));
    cyc(3);
    chk("pdn_pwr", 0, O_PWR_EN);
    chk("pdn_clk", 0, O_CLK_OE);
    chk("pdn_rdy", 1, O_RDY_N);
    close_out();
  end
endmodule // tb
